// ===== common/throttle_pkg.sv
package throttle_pkg;

  // Register map, word aligned byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;  // thermal_ctrl_word
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PERF   = 4'h8;  // perf_status_word
  localparam logic [3:0] REG_VCODE  = 4'hC;

  // thermal_ctrl_word fields
  localparam int CTRL_OD_EN    = 4;
  localparam int CTRL_DUTY_LO  = 1;
  localparam int CTRL_MOD_EN   = 8;
  localparam int CTRL_FV_EN    = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status fields
  localparam int STS_HOT      = 0;
  localparam int STS_ENGAGED  = 1;
  localparam int STS_CLK_RUN  = 2;
  localparam int STS_FV_BUSY  = 3;
  localparam int STS_BUS_BLK  = 4;
  localparam int STS_IRQ_PEND = 5;

  // Timing
  localparam int CLK_MHZ           = 100;
  localparam int OFF_MAX_NS        = 3000;
  localparam int OFF_MAX_CYC       = OFF_MAX_NS * CLK_MHZ / 1000;
  localparam int FREQ_CHANGE_US    = 5;
  localparam int FREQ_CHANGE_CYC   = FREQ_CHANGE_US * CLK_MHZ;
  localparam int MOD_PERIOD_CYC    = 400;
  localparam int FACTORY_ON_CYC    = 160;
  localparam int HYST_CYC_DEF      = 10000;
  localparam int VSTEP_CYC_DEF     = 50;

  localparam logic [5:0] MULT_LOW_DEF  = 6'h0C;
  localparam logic [5:0] MULT_NORM_DEF = 6'h12;
  localparam logic [5:0] VCODE_NORM_DEF = 6'h10;
  localparam logic [5:0] VCODE_LOW_DEF  = 6'h18;

  typedef enum logic [2:0] {
    FV_NORMAL   = 3'b000,
    FV_FREQ_DN  = 3'b001,
    FV_VOLT_DN  = 3'b011,
    FV_LOW      = 3'b010,
    FV_VOLT_UP  = 3'b110,
    FV_FREQ_UP  = 3'b111
  } fv_state_t;

  typedef struct packed {
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } av_rsp_t;

endpackage : throttle_pkg

// ===== core/thermal_throttle_control.sv
`timescale 1ns/1ps
module thermal_throttle_control
  import throttle_pkg::*;
#(
  parameter int         HYST_CYC    = HYST_CYC_DEF,
  parameter int         VSTEP_CYC   = VSTEP_CYC_DEF,
  parameter logic [5:0] MULT_LOW    = MULT_LOW_DEF,
  parameter logic [5:0] VCODE_NORM  = VCODE_NORM_DEF,
  parameter logic [5:0] VCODE_LOW   = VCODE_LOW_DEF
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire throttle_pkg::av_req_t av_req,
  output      throttle_pkg::av_rsp_t av_rsp,
  input  wire logic                 sensor_hot,
  input  wire logic                 overtemp_flag_n_in,
  output      logic                 overtemp_flag_n_out,
  output      logic                 overtemp_flag_n_oe,
  input  wire logic                 irq_edge,
  output      logic                 irq_service,
  output      logic                 core_clk_en,
  output      logic                 bus_block,
  output      logic [5:0]           bus_multiplier,
  output      logic [5:0]           voltage_select_code
);
  import throttle_pkg::*;

  if (HYST_CYC < 1 || HYST_CYC > 65535) begin : g_bad_hyst
    $error("HYST_CYC out of range");
  end
  if (VSTEP_CYC < 1 || VSTEP_CYC > 1023) begin : g_bad_vstep
    $error("VSTEP_CYC out of range");
  end
  if (VCODE_LOW < VCODE_NORM) begin : g_bad_vcode
    $error("VCODE_LOW must be above VCODE_NORM");
  end

  // Factory modulation must keep off time within bound
  localparam int FACT_OFF = MOD_PERIOD_CYC - FACTORY_ON_CYC;
  if (FACT_OFF > OFF_MAX_CYC) begin : g_bad_off
    $error("Factory off time too long");
  end

  typedef struct packed {
    logic [31:0] ctrl;
    logic [5:0]  perf;
    logic        engaged;
    logic [15:0] hyst;
    logic [8:0]  phase;
    fv_state_t   fv;
    logic [9:0]  tmr;
    logic [5:0]  vcode;
    logic [5:0]  mult;
    logic        irq_pend;
    logic        irq_svc;
    logic [31:0] rdata;
    logic        rvalid;
  } state_t;

  state_t st;
  state_t next_st;

  logic hot;
  logic mod_en;
  logic fv_en;
  logic od_en;
  logic [8:0] on_cyc;
  logic clk_run;
  logic access;
  logic mapped;

  // External pull-low counts as hot; our own drive only mirrors sensor_hot
  assign hot    = sensor_hot | ~overtemp_flag_n_in;
  assign mod_en = st.ctrl[CTRL_MOD_EN];
  assign fv_en  = st.ctrl[CTRL_FV_EN];
  assign od_en  = st.ctrl[CTRL_OD_EN];
  assign access = av_req.read | av_req.write;
  // Upper address bits must be zero, or high offsets would alias the map
  assign mapped = (av_req.address[31:4] == 28'h000_0000);

  always_comb begin
    // Factory duty wins while engaged with modulation on; on-demand eighths of the period otherwise
    if (st.engaged && mod_en) begin
      on_cyc = 9'(FACTORY_ON_CYC);
    end else begin
      on_cyc = 9'((int'(st.ctrl[CTRL_DUTY_LO +: 3]) * MOD_PERIOD_CYC) / 8);
    end
    if (st.engaged && mod_en) begin
      clk_run = (st.phase < on_cyc);
    end else if (od_en && st.ctrl[CTRL_DUTY_LO +: 3] != 3'h0) begin
      clk_run = (st.phase < on_cyc);
    end else begin
      clk_run = 1'b1;
    end
  end

  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.irq_svc = 1'b0;

    next_st.phase = (st.phase == 9'(MOD_PERIOD_CYC - 1)) ? 9'h0 : st.phase + 9'h1;

    // Engage on heat with modulation or freq-volt on; release only when that ends and timer has run out
    if (hot && (mod_en || fv_en)) begin
      next_st.engaged = 1'b1;
      next_st.hyst    = 16'(HYST_CYC);
    end else if (st.engaged) begin
      if (st.hyst != 16'h0) begin
        next_st.hyst = st.hyst - 16'h1;
      end else begin
        next_st.engaged = 1'b0;
      end
    end

    if (st.tmr != 10'h0) next_st.tmr = st.tmr - 10'h1;
    unique case (st.fv)
      FV_NORMAL: begin
        next_st.mult = st.perf;
        if (st.engaged && fv_en) begin
          next_st.fv   = FV_FREQ_DN;
          next_st.tmr  = 10'(FREQ_CHANGE_CYC - 1);
          next_st.mult = MULT_LOW;
        end
      end
      FV_FREQ_DN: begin
        if (st.tmr == 10'h0) begin
          next_st.fv  = FV_VOLT_DN;
          next_st.tmr = 10'(VSTEP_CYC - 1);
        end
      end
      FV_VOLT_DN: begin
        if (st.tmr == 10'h0) begin
          if (st.vcode == VCODE_LOW) begin
            next_st.fv = FV_LOW;
          end else begin
            next_st.vcode = st.vcode + 6'h1;
            next_st.tmr   = 10'(VSTEP_CYC - 1);
          end
        end
      end
      FV_LOW: begin
        if (!st.engaged) begin
          next_st.fv  = FV_VOLT_UP;
          next_st.tmr = 10'(VSTEP_CYC - 1);
        end
      end
      FV_VOLT_UP: begin
        if (st.tmr == 10'h0) begin
          if (st.vcode == VCODE_NORM) begin
            next_st.fv   = FV_FREQ_UP;
            next_st.tmr  = 10'(FREQ_CHANGE_CYC - 1);
            next_st.mult = st.perf;
          end else begin
            next_st.vcode = st.vcode - 6'h1;
            next_st.tmr   = 10'(VSTEP_CYC - 1);
          end
        end
      end
      FV_FREQ_UP: begin
        if (st.tmr == 10'h0) next_st.fv = FV_NORMAL;
      end
      default: next_st.fv = FV_NORMAL;
    endcase

    // Interrupts wait for running clocks and an open bus; a new edge wins over service
    if (st.irq_pend && clk_run && !bus_block) begin
      next_st.irq_svc  = 1'b1;
      next_st.irq_pend = 1'b0;
    end
    if (irq_edge) next_st.irq_pend = 1'b1;

    // Register slave: bus is stalled during a frequency change
    if (access && !bus_block && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = 32'h0000_0000;
      if (av_req.write && mapped) begin
        unique case (av_req.address[3:0])
          REG_CTRL: next_st.ctrl = av_req.writedata & 32'h0000_031E;
          REG_PERF: next_st.perf = av_req.writedata[5:0];
          default: ;
        endcase
      end else if (av_req.read && mapped) begin
        unique case (av_req.address[3:0])
          REG_CTRL:   next_st.rdata = st.ctrl;
          REG_STATUS: next_st.rdata = {26'h0, st.irq_pend, bus_block,
                                       (st.fv != FV_NORMAL), clk_run,
                                       st.engaged, hot};
          REG_PERF:   next_st.rdata = {26'h0, st.perf};
          REG_VCODE:  next_st.rdata = {18'h0_0000, st.mult, 2'h0, st.vcode};
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st       <= '0;
      st.ctrl  <= CTRL_RESET;
      st.perf  <= MULT_NORM_DEF;
      st.mult  <= MULT_NORM_DEF;
      st.vcode <= VCODE_NORM;
      st.fv    <= FV_NORMAL;
    end else begin
      st <= next_st;
    end
  end

  assign bus_block           = (st.fv == FV_FREQ_DN) || (st.fv == FV_FREQ_UP);
  assign overtemp_flag_n_out = 1'b0;
  assign overtemp_flag_n_oe  = sensor_hot;
  assign core_clk_en         = clk_run;
  assign irq_service         = st.irq_svc;
  assign bus_multiplier      = st.mult;
  assign voltage_select_code = st.vcode;
  assign av_rsp.readdata     = st.rdata;
  assign av_rsp.waitrequest  = !st.rvalid;

  a_hot_pin: assert property (@(posedge clk) disable iff (rst)
    sensor_hot |-> overtemp_flag_n_oe && !overtemp_flag_n_out)
    else $error("Over-temperature pin not driven while hot");
  a_engage_hot: assert property (@(posedge clk) disable iff (rst)
    hot && mod_en |=> st.engaged)
    else $error("Throttle did not engage");
  a_no_engage: assert property (@(posedge clk) disable iff (rst)
    !mod_en && !fv_en && !od_en |-> core_clk_en && st.fv != FV_FREQ_DN)
    else $error("Throttling without enable");
  a_hyst_hold: assert property (@(posedge clk) disable iff (rst)
    st.engaged && st.hyst != 16'h0 |=> st.engaged)
    else $error("Released before hysteresis expired");
  a_freq_block: assert property (@(posedge clk) disable iff (rst)
    $rose(st.fv == FV_FREQ_DN) |-> bus_block [*8])
    else $error("Bus not blocked during frequency change");
  a_bus_stall: assert property (@(posedge clk) disable iff (rst)
    bus_block |-> av_rsp.waitrequest)
    else $error("Bus answered during frequency change");
  a_volt_first: assert property (@(posedge clk) disable iff (rst)
    st.fv == FV_VOLT_UP |-> bus_multiplier == MULT_LOW)
    else $error("Frequency raised before voltage restored");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq_service |-> $past(core_clk_en) && !$past(bus_block))
    else $error("Interrupt serviced with clocks stopped");
  a_vstep_one: assert property (@(posedge clk) disable iff (rst)
    $changed(voltage_select_code) |-> !bus_block)
    else $error("Voltage stepped during frequency change");
  a_off_bound: assert property (@(posedge clk) disable iff (rst)
    st.engaged && mod_en && !core_clk_en |-> ##[1:300] core_clk_en)
    else $error("Clock off too long");

  c_mod_engage: cover property (@(posedge clk) disable iff (rst)
    st.engaged && mod_en && !core_clk_en);
  c_fv_low: cover property (@(posedge clk) disable iff (rst) st.fv == FV_LOW);
  c_fv_return: cover property (@(posedge clk) disable iff (rst)
    st.fv == FV_FREQ_UP ##1 st.fv == FV_NORMAL);
  c_ondemand: cover property (@(posedge clk) disable iff (rst)
    od_en && !st.engaged && !core_clk_en);

endmodule // thermal_throttle_control

// ===== tb/vreg_model.sv
`timescale 1ns/1ps
module vreg_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [5:0] voltage_select_code,
  input  wire logic       overtemp_flag_n_out,
  input  wire logic       overtemp_flag_n_oe,
  input  wire logic       ext_hot,
  output      logic       pin_level,
  output      logic [7:0] step_err,
  output      logic [7:0] steps
);
  logic [5:0] applied;
  // Pull-up: the line reads high unless the device or the board sinks it
  assign pin_level = ~((overtemp_flag_n_oe & ~overtemp_flag_n_out) | ext_hot);
  // Regulator follows each code change; a jump of more than one entry is logged
  always @(posedge clk) begin
    if (rst) begin
      applied  <= voltage_select_code;
      step_err <= 8'h00;
      steps    <= 8'h00;
    end else if (voltage_select_code !== applied) begin
      applied <= voltage_select_code;
      steps   <= steps + 8'h01;
      if (voltage_select_code - applied != 1 && applied - voltage_select_code != 1)
        step_err <= step_err + 8'h01;
    end
  end
endmodule // vreg_model

// ===== tb/tb_thermal_throttle_control.sv
`timescale 1ns/1ps
module tb_thermal_throttle_control;
  import throttle_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic       clk, rst, sensor_hot, ext_hot, irq_edge, pin_level;
  logic       ot_out, ot_oe, irq_service, core_clk_en, bus_block;
  logic [5:0] bus_multiplier, voltage_select_code;
  logic [7:0] step_err, steps;
  logic [31:0] q;
  av_req_t    av_req;
  av_rsp_t    av_rsp;
  int         error_cnt, num_checks, blk_cnt, last_blk, services, s, on, maxoff, t;
  row_t rows [13] = '{'{0, 8'h00, 0, 32'h0}, '{0, 8'h04, 0, 32'h4}, '{0, 8'h08, 0, 32'h12},
    '{0, 8'h0C, 0, 32'h1210}, '{0, 8'h10, 0, 32'h0}, '{1, 8'h10, 32'hFFFF_FFFF, 0},
    '{1, 8'h04, 32'hFFFF_FFFF, 0}, '{0, 8'h04, 0, 32'h4}, '{0, 8'h10, 0, 32'h0},
    '{1, 8'h08, 32'h14, 0}, '{0, 8'h08, 0, 32'h14}, '{1, 8'h00, 32'h1E, 0},
    '{0, 8'h00, 0, 32'h1E}};

  thermal_throttle_control #(.HYST_CYC(20), .VSTEP_CYC(3)) u_dut (.clk(clk), .rst(rst),
    .av_req(av_req), .av_rsp(av_rsp), .sensor_hot(sensor_hot), .overtemp_flag_n_in(pin_level),
    .overtemp_flag_n_out(ot_out), .overtemp_flag_n_oe(ot_oe), .irq_edge(irq_edge),
    .irq_service(irq_service), .core_clk_en(core_clk_en), .bus_block(bus_block),
    .bus_multiplier(bus_multiplier), .voltage_select_code(voltage_select_code));
  vreg_model u_vr (.clk(clk), .rst(rst), .voltage_select_code(voltage_select_code),
    .overtemp_flag_n_out(ot_out), .overtemp_flag_n_oe(ot_oe), .ext_hot(ext_hot),
    .pin_level(pin_level), .step_err(step_err), .steps(steps));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task expect_eq(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_req.address <= {24'h00_0000, a};
    av_req.writedata <= d;
    av_req.write <= wr;
    av_req.read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 2000);
    q = av_rsp.readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk);
  endtask

  // Counts cycles with core clocks running and the longest stopped run
  task run(input int n);
    int off;
    on = 0;
    maxoff = 0;
    off = 0;
    repeat (n) begin
      @(posedge clk);
      if (core_clk_en === 1'b1) begin
        on++;
        off = 0;
      end else begin
        off++;
        if (off > maxoff) maxoff = off;
      end
    end
  endtask

  task pulse_irq;
    irq_edge <= 1'b1;
    @(posedge clk);
    irq_edge <= 1'b0;
  endtask

  always @(posedge clk) begin
    if (bus_block === 1'b1) blk_cnt <= blk_cnt + 1;
    else if (blk_cnt != 0) begin
      last_blk <= blk_cnt;
      blk_cnt <= 0;
    end
    if (irq_service === 1'b1) begin
      services <= services + 1;
      expect_eq(core_clk_en & ~bus_block, 1, "interrupt served while stopped");
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report;
  end

  initial begin
    rst = 1'b1; sensor_hot = 1'b0; ext_hot = 1'b0; irq_edge = 1'b0; av_req = '0;
    error_cnt = 0; num_checks = 0; blk_cnt = 0; last_blk = 0; services = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) expect_eq(q, rows[i].e, "register read");
    end
    // Hot with no mode enabled: flag only
    bus(1, 8'h00, 32'h0);
    sensor_hot <= 1'b1;
    run(600);
    expect_eq(on, 600, "clock gated with no mode");
    expect_eq({ot_oe, ot_out, pin_level}, 3'b100, "overtemp flag");
    sensor_hot <= 1'b0;
    bus(1, 8'h00, 32'h100);
    sensor_hot <= 1'b1;
    repeat (4) @(posedge clk);
    run(800);
    expect_eq(on, 2 * FACTORY_ON_CYC, "factory duty");
    expect_eq(maxoff <= OFF_MAX_CYC, 1, "clock off too long");
    bus(1, 8'h00, 32'h11E);
    run(800);
    expect_eq(on, 2 * FACTORY_ON_CYC, "on-demand duty took over");
    t = 0;
    while (core_clk_en !== 1'b0 && t < 500) begin @(posedge clk); t++; end
    s = services;
    pulse_irq;
    repeat (400) @(posedge clk);
    expect_eq(services, s + 1, "latched interrupt lost");
    sensor_hot <= 1'b0;
    bus(1, 8'h00, 32'h100);
    bus(0, 8'h04, 32'h0);
    expect_eq(q[STS_ENGAGED], 1, "released before hysteresis");
    repeat (30) @(posedge clk);
    run(400);
    expect_eq(on, 400, "modulation after cooling");
    // Software duties with freq-volt enabled but cold
    for (int n = 1; n < 8; n++) begin
      bus(1, 8'h00, 32'h210 | (n << 1));
      run(400);
      run(400);
      expect_eq(on, n * 50, "on-demand duty");
      expect_eq(last_blk, 0, "on-demand started freq change");
    end
    bus(1, 8'h00, 32'h200);
    sensor_hot <= 1'b1;
    t = 0;
    while (bus_block !== 1'b1 && t < 20) begin @(posedge clk); t++; end
    expect_eq(bus_multiplier, MULT_LOW_DEF, "frequency not lowered");
    expect_eq(voltage_select_code, VCODE_NORM_DEF, "voltage moved first");
    s = services;
    pulse_irq;
    bus(0, 8'h04, 32'h0);
    expect_eq(last_blk, FREQ_CHANGE_CYC, "bus answered during change");
    run(40);
    expect_eq(on, 40, "stall while stepping");
    expect_eq(services, s + 1, "edge interrupt not held");
    expect_eq(voltage_select_code, VCODE_LOW_DEF, "low voltage code");
    expect_eq(steps, 8, "voltage step count");
    sensor_hot <= 1'b0;
    t = 0;
    while (bus_multiplier === MULT_LOW_DEF && t < 300) begin @(posedge clk); t++; end
    expect_eq(voltage_select_code, VCODE_NORM_DEF, "frequency before voltage");
    expect_eq(t > 20, 1, "returned before hysteresis");
    repeat (520) @(posedge clk);
    expect_eq({steps, step_err}, {8'd16, 8'd0}, "voltage steps");
    expect_eq(bus_multiplier, 6'h14, "normal multiplier");
    // Board pulls the flag low
    bus(1, 8'h00, 32'h100);
    ext_hot <= 1'b1;
    repeat (4) @(posedge clk);
    run(800);
    expect_eq(on, 320, "external hot duty");
    expect_eq({31'h0, ot_oe}, 0, "external hot drove pin");
    ext_hot <= 1'b0;
    final_report;
  end
endmodule // tb_thermal_throttle_control
